// ===== include/iom_pkg.sv
package iom_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_CMD_CODE = 16'h1f3f;
  localparam logic [15:0] ADDR_PARAM_COUNT = 16'h1f40;
  localparam logic [15:0] ADDR_DEST_SELECT = 16'h1f41;
  localparam logic [15:0] ADDR_SEC_TYPE = 16'h1f42;
  localparam logic [15:0] ADDR_PW_HI = 16'h1f43;
  localparam logic [15:0] ADDR_PW_LO = 16'h1f44;
  localparam logic [15:0] ADDR_PARAM_ONE = 16'h1f45;
  localparam logic [15:0] ADDR_PARAM_TWO = 16'h1f46;
  localparam logic [15:0] ADDR_LAST_CODE = 16'h1f53;
  localparam logic [15:0] ADDR_CMD_STATUS = 16'h1f54;
  localparam logic [15:0] ADDR_ALARM_STATUS = 16'h1f61;
  localparam logic [15:0] ADDR_OUTPUT_STATUS = 16'h1f62;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [15:0] CMD_CHANGE_OUTPUT = 16'd1672;
  localparam logic [15:0] CMD_RESET_ALARMS = 16'd41099;
  localparam logic [15:0] CMD_SIMPLE_ENABLE = 16'd41100;
  localparam logic [15:0] CMD_ACK_LATCH = 16'd41102;
  localparam logic [15:0] CMD_PRESET_CRADLE_CNT = 16'd41352;
  localparam logic [15:0] CMD_PRESET_REGREASE = 16'd41353;
  localparam logic [15:0] CMD_LIGHT_CONTROL = 16'd42120;
  localparam logic [15:0] CMD_LOAD_CONTROL = 16'd42376;
  localparam logic [15:0] CMD_PRESET_PULSE_CNT = 16'd42888;
  localparam logic [15:0] CMD_PRESET_TEMP_CNT = 16'd42889;
  localparam logic [15:0] CMD_RESET_MINMAX = 16'd42890;
  localparam logic [15:0] CMD_GET_EVENTS = 16'd50560;

  // ---------------------------------------------------------------
  // Field values
  // ---------------------------------------------------------------
  localparam logic [15:0] DEST_FIRST = 16'h2001;
  localparam logic [15:0] DEST_SECOND = 16'h2101;
  localparam logic [15:0] SEC_PASSWORD = 16'h0001;
  localparam logic [15:0] SEC_NONE = 16'h0000;
  localparam logic [15:0] COUNT_CHANGE_OUTPUT = 16'd13;
  localparam logic [15:0] COUNT_PW_ONLY = 16'd10;
  localparam logic [15:0] COUNT_ONE_PARAM = 16'd11;
  localparam logic [15:0] COUNT_GET_EVENTS = 16'd27;
  localparam logic [15:0] VALUE_OFF = 16'h0000;
  localparam logic [15:0] VALUE_ON = 16'h0100;
  localparam logic [7:0] RELAY_ALL = 8'hff;
  localparam logic [15:0] METHOD_RECENT = 16'h0000;
  localparam logic [15:0] METHOD_BEFORE_SEQ = 16'h0002;

  // ---------------------------------------------------------------
  // Shared error set and sizes
  // ---------------------------------------------------------------
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_BAD_CODE = 16'h0001;
  localparam logic [15:0] ERR_NOT_CONFIGURED = 16'h0002;
  localparam logic [15:0] ERR_BAD_COUNT = 16'h0003;
  localparam logic [15:0] ERR_BAD_SECURITY = 16'h0004;
  localparam logic [15:0] ERR_BAD_PASSWORD = 16'h0005;
  localparam logic [15:0] ERR_BAD_PARAM = 16'h0006;
  localparam int NUM_OUT = 3;
  localparam int NUM_ALARM = 8;
  localparam logic [2:0] RST_OUT = 3'h0;
  localparam logic RST_SIMPLE_EN = 1'b1;

  // Configured applications
  typedef struct packed {
    logic cradle_drawer;
    logic light;
    logic load;
    logic pulse_count;
    logic cooling;
  } iom_app_cfg_s;

  // Register write and read strobes
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [15:0] addr;
    logic [15:0] wdata;
  } iom_reg_req_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CHECK = 3'b010,
    ST_EXEC = 3'b100
  } iom_state_e;

  // Command block as written by the master
  typedef struct packed {
    logic [15:0] code;
    logic [15:0] count;
    logic [15:0] dest;
    logic [15:0] sec;
    logic [15:0] pw_hi;
    logic [15:0] pw_lo;
    logic [15:0] p1;
    logic [15:0] p2;
  } iom_cmd_s;

  // Whole state of the handler
  typedef struct packed {
    iom_state_e state;
    logic busy;
    iom_cmd_s cmd;
    logic [15:0] err;
    logic [15:0] last_code;
    logic [15:0] status;
    logic [2:0] dout;
    logic [2:0] latched;
    logic simple_en;
    logic [7:0] alarm;
    logic [7:0] alarm_s1;
    logic [7:0] alarm_s2;
    logic sel_s1;
    logic sel_s2;
    logic second_module;
    logic minmax_clr;
    logic evt_req;
    logic [15:0] evt_method;
    logic app_go;
    logic [15:0] app_code;
    logic [15:0] rd_data;
    logic rd_valid;
  } iom_st_s;

endpackage : iom_pkg

// ===== rtl/iom_cmd_handler.sv
`timescale 1ns/100ps
// Overview of operation
// - Application commands need their application configured
// - 1672 changes output, needs password
// - 41099 resets alarms, 41100 switches simple commands on or off
// - 41102 unlatches output, 42890 resets min/max
// - 50560 gets events, no password check
// - 41352/41353 preset cradle counters and timers
// - 42120 light, 42376 load, when configured
// - 42888 pulse, 42889 temperature counter presets
// - Security type 1, admin or operator password
// - Change output: count 13, output 1-3
// - Value 0x0000 is OFF, 0x0100 ON
// - Only user-defined outputs may change
// - Reset alarms: count 10, clears resettable alarms
// - Simple commands: high byte 0 off, 1 on
// - Unlatch relay 1-3, or 0xFF for all
// - Failures use the shared error set only
// - Alarm status register is readable
// - Report executed code and status word
module iom_cmd_handler
  import iom_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire iom_reg_req_s req,
  input wire logic frame_done,
  input wire logic module_strap,
  input wire iom_app_cfg_s app_cfg,
  input wire logic [2:0] out_user_def,
  input wire logic [31:0] admin_pw,
  input wire logic [31:0] oper_pw,
  input wire logic [7:0] alarm_in,
  input wire logic [7:0] alarm_resettable,
  input wire logic [2:0] latch_set,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic busy,
  output logic [2:0] dout,
  output logic [2:0] relay_latched,
  output logic simple_cmd_en,
  output logic minmax_clear,
  output logic evt_req,
  output logic [15:0] evt_method,
  output logic app_cmd_go,
  output logic [15:0] app_cmd_code
);

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  iom_st_s s_q;
  iom_st_s s_d;

  // ---------------------------------------------------------------
  // Per-output next values
  // ---------------------------------------------------------------
  logic [2:0] sel_hit;
  logic [2:0] unlatch_hit;
  logic do_change;
  logic do_unlatch;
  logic [7:0] relay_sel;

  assign relay_sel = s_q.cmd.p1[15:8];
  assign do_change = s_q.state == ST_EXEC && s_q.err == ERR_NONE &&
                     s_q.cmd.code == CMD_CHANGE_OUTPUT;
  assign do_unlatch = s_q.state == ST_EXEC && s_q.err == ERR_NONE &&
                      s_q.cmd.code == CMD_ACK_LATCH;

  // One slice per output: decode which one the command names
  for (genvar i = 0; i < NUM_OUT; i++)
  begin : g_out
    assign sel_hit[i] = do_change &&
                        s_q.cmd.p1 == 16'(i + 1);
    assign unlatch_hit[i] = do_unlatch && (relay_sel == RELAY_ALL ||
                            relay_sel == 8'(i + 1));
  end

  // ---------------------------------------------------------------
  // Command check, execution and register access
  // ---------------------------------------------------------------
  always_comb
  begin
    logic pw_ok;
    logic [31:0] pw;
    logic [15:0] own_dest;
    logic [15:0] e;
    logic [7:0] hi;
    pw = {s_q.cmd.pw_hi, s_q.cmd.pw_lo};
    pw_ok = pw == admin_pw || pw == oper_pw;
    own_dest = s_q.second_module ? DEST_SECOND : DEST_FIRST;
    hi = s_q.cmd.p1[15:8];
    e = ERR_NONE;
    s_d = s_q;

    // Single-cycle strobes
    s_d.minmax_clr = 1'b0;
    s_d.evt_req = 1'b0;
    s_d.app_go = 1'b0;
    s_d.rd_valid = 1'b0;

    // Two-flop synchronisers for pins
    s_d.alarm_s1 = alarm_in;
    s_d.alarm_s2 = s_q.alarm_s1;
    s_d.sel_s1 = module_strap;
    s_d.sel_s2 = s_q.sel_s1;
    // Strap follows its synchronised pin; only idle, so no
    // command ever sees the destination change under it
    if (s_q.state == ST_IDLE)
    begin
      s_d.second_module = s_q.sel_s2;
    end

    // Generic password check, shared by protected commands
    if (s_q.cmd.sec != SEC_PASSWORD)
    begin
      e = ERR_BAD_SECURITY;
    end
    else if (!pw_ok)
    begin
      e = ERR_BAD_PASSWORD;
    end

    // Per-code checks; later checks override the password
    // result where the layout is wrong, the code is unknown,
    // the application is not configured, or for event requests
    unique case (s_q.cmd.code)
      CMD_CHANGE_OUTPUT:
      begin
        if (s_q.cmd.count != COUNT_CHANGE_OUTPUT)
          e = ERR_BAD_COUNT;
        else if (e == ERR_NONE && (s_q.cmd.p1 == 16'h0000 ||
                 s_q.cmd.p1 > 16'(NUM_OUT)))
          e = ERR_BAD_PARAM;
        else if (e == ERR_NONE && s_q.cmd.p2 != VALUE_OFF &&
                 s_q.cmd.p2 != VALUE_ON)
          e = ERR_BAD_PARAM;
        else if (e == ERR_NONE &&
                 !out_user_def[s_q.cmd.p1[1:0] - 2'd1])
          e = ERR_BAD_PARAM;
      end
      CMD_RESET_ALARMS, CMD_RESET_MINMAX:
      begin
        if (s_q.cmd.count != COUNT_PW_ONLY)
          e = ERR_BAD_COUNT;
      end
      CMD_SIMPLE_ENABLE:
      begin
        if (s_q.cmd.count != COUNT_ONE_PARAM)
          e = ERR_BAD_COUNT;
        else if (e == ERR_NONE && hi > 8'h01)
          e = ERR_BAD_PARAM;
      end
      CMD_ACK_LATCH:
      begin
        if (s_q.cmd.count != COUNT_ONE_PARAM)
          e = ERR_BAD_COUNT;
        else if (e == ERR_NONE && hi != RELAY_ALL &&
                 (hi == 8'h00 || hi > 8'(NUM_OUT)))
          e = ERR_BAD_PARAM;
      end
      CMD_GET_EVENTS:
      begin
        // No password: only security type, layout and method checked
        if (s_q.cmd.count != COUNT_GET_EVENTS)
          e = ERR_BAD_COUNT;
        else if (s_q.cmd.sec != SEC_NONE)
          e = ERR_BAD_SECURITY;
        else if (s_q.cmd.p2 != METHOD_RECENT &&
                 s_q.cmd.p2 != METHOD_BEFORE_SEQ)
          e = ERR_BAD_PARAM;
        else
          e = ERR_NONE;
      end
      CMD_PRESET_CRADLE_CNT, CMD_PRESET_REGREASE:
      begin
        if (!app_cfg.cradle_drawer)
          e = ERR_NOT_CONFIGURED;
      end
      CMD_LIGHT_CONTROL:
      begin
        if (!app_cfg.light)
          e = ERR_NOT_CONFIGURED;
      end
      CMD_LOAD_CONTROL:
      begin
        if (!app_cfg.load)
          e = ERR_NOT_CONFIGURED;
      end
      CMD_PRESET_PULSE_CNT:
      begin
        if (!app_cfg.pulse_count)
          e = ERR_NOT_CONFIGURED;
      end
      CMD_PRESET_TEMP_CNT:
      begin
        if (!app_cfg.cooling)
          e = ERR_NOT_CONFIGURED;
      end
      default:
      begin
        e = ERR_BAD_CODE;
      end
    endcase

    // Sequencer: block is taken at the end of the write frame
    unique case (s_q.state)
      ST_IDLE:
      begin
        // Other module's commands are left alone entirely
        if (frame_done && s_q.cmd.dest == own_dest)
        begin
          s_d.state = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        s_d.err = e;
        s_d.state = ST_EXEC;
      end
      ST_EXEC:
      begin
        s_d.state = ST_IDLE;
        s_d.last_code = s_q.cmd.code;
        s_d.status = s_q.err;
        if (s_q.err == ERR_NONE)
        begin
          unique case (s_q.cmd.code)
            CMD_SIMPLE_ENABLE:
              s_d.simple_en = hi[0];
            CMD_RESET_MINMAX:
              s_d.minmax_clr = 1'b1;
            CMD_GET_EVENTS:
            begin
              s_d.evt_req = 1'b1;
              s_d.evt_method = s_q.cmd.p2;
            end
            CMD_PRESET_CRADLE_CNT, CMD_PRESET_REGREASE,
            CMD_LIGHT_CONTROL, CMD_LOAD_CONTROL,
            CMD_PRESET_PULSE_CNT, CMD_PRESET_TEMP_CNT:
            begin
              s_d.app_go = 1'b1;
              s_d.app_code = s_q.cmd.code;
            end
            default:
            begin
            end
          endcase
        end
      end
    endcase
    // Busy has a flop of its own so the port never glitches
    s_d.busy = s_d.state != ST_IDLE;

    // Outputs and latches; a new latch event beats an unlatch
    for (int i = 0; i < NUM_OUT; i++)
    begin
      if (sel_hit[i])
        s_d.dout[i] = s_q.cmd.p2 == VALUE_ON;
      if (unlatch_hit[i])
        s_d.latched[i] = 1'b0;
      if (latch_set[i])
        s_d.latched[i] = 1'b1;
    end

    // Alarms: raised by pin level, reset command clears the
    // resettable ones, a still-present alarm sets again
    if (s_q.state == ST_EXEC && s_q.err == ERR_NONE &&
        s_q.cmd.code == CMD_RESET_ALARMS)
    begin
      s_d.alarm = s_q.alarm & ~alarm_resettable;
    end
    s_d.alarm = s_d.alarm | s_q.alarm_s2;

    // Command block writes, refused while a command runs
    if (req.wr_en && s_q.state == ST_IDLE)
    begin
      unique case (req.addr)
        ADDR_CMD_CODE: s_d.cmd.code = req.wdata;
        ADDR_PARAM_COUNT: s_d.cmd.count = req.wdata;
        ADDR_DEST_SELECT: s_d.cmd.dest = req.wdata;
        ADDR_SEC_TYPE: s_d.cmd.sec = req.wdata;
        ADDR_PW_HI: s_d.cmd.pw_hi = req.wdata;
        ADDR_PW_LO: s_d.cmd.pw_lo = req.wdata;
        ADDR_PARAM_ONE: s_d.cmd.p1 = req.wdata;
        ADDR_PARAM_TWO: s_d.cmd.p2 = req.wdata;
        default:
        begin
        end
      endcase
    end

    // Reads answer one cycle later; write-only words read zero
    if (req.rd_en)
    begin
      s_d.rd_valid = 1'b1;
      unique case (req.addr)
        ADDR_LAST_CODE: s_d.rd_data = s_q.last_code;
        ADDR_CMD_STATUS: s_d.rd_data = s_q.status;
        ADDR_ALARM_STATUS: s_d.rd_data = {8'h00, s_q.alarm};
        ADDR_OUTPUT_STATUS:
          s_d.rd_data = {8'h00, 1'b0, s_q.simple_en,
                         s_q.latched, s_q.dout};
        default: s_d.rd_data = 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register stage with synchronous reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.state <= ST_IDLE;
      s_q.dout <= RST_OUT;
      s_q.simple_en <= RST_SIMPLE_EN;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from flops
  // ---------------------------------------------------------------
  assign rd_data = s_q.rd_data;
  assign rd_valid = s_q.rd_valid;
  assign busy = s_q.busy; // Registered beside the state
  assign dout = s_q.dout;
  assign relay_latched = s_q.latched;
  assign simple_cmd_en = s_q.simple_en;
  assign minmax_clear = s_q.minmax_clr;
  assign evt_req = s_q.evt_req;
  assign evt_method = s_q.evt_method;
  assign app_cmd_go = s_q.app_go;
  assign app_cmd_code = s_q.app_code;

endmodule : iom_cmd_handler

// ===== testbench/iom_cmd_handler_sva.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Handler port checker
// ---------------------------------------------------------------
module iom_chk
  import iom_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire iom_reg_req_s req,
  input wire logic frame_done,
  input wire logic [2:0] latch_set,
  input wire logic rd_valid,
  input wire logic busy,
  input wire logic [2:0] dout,
  input wire logic [2:0] relay_latched,
  input wire logic simple_cmd_en,
  input wire logic minmax_clear,
  input wire logic evt_req,
  input wire logic [15:0] evt_method,
  input wire logic app_cmd_go
);
  // Single domain, so one clocking and one disable serve all
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Reads answer exactly one cycle later
  a_read_answer: assert property (req.rd_en |=> rd_valid)
    else $error("read not answered");
  a_read_once: assert property (!req.rd_en |=> !rd_valid)
    else $error("stray read answer");
  // Check and execute take two busy cycles
  a_busy_two: assert property ($rose(busy) |=> busy ##1 !busy)
    else $error("busy length wrong");
  a_idle_quiet: assert property (!busy && !frame_done |=> !busy)
    else $error("busy without trigger");
  // State outputs move only as a command completes, except latch_set raising a latch at once
  a_dout_exec: assert property ($changed(dout) |-> $past(busy))
    else $error("output moved outside command");
  a_simple_exec: assert property ($changed(simple_cmd_en) |->
    $past(busy))
    else $error("simple enable moved outside command");
  a_unlatch_exec: assert property ($fell(relay_latched[0]) |->
    $past(busy))
    else $error("unlatch outside command");
  a_latch_wins: assert property (latch_set[0] |=> relay_latched[0])
    else $error("latch set lost");
  // Pulses stand one cycle, right after execution
  a_pulse_one: assert property (minmax_clear |=> !minmax_clear)
    else $error("clear pulse too long");
  a_evt_method: assert property (evt_req |-> $past(busy) && !busy &&
    (evt_method == METHOD_RECENT || evt_method == METHOD_BEFORE_SEQ))
    else $error("event request malformed");
  a_go_exec: assert property (app_cmd_go |->
    $past(busy) ##1 !app_cmd_go)
    else $error("application start malformed");

  // Main scenarios reached
  c_evt: cover property (evt_req);
  c_minmax: cover property (minmax_clear);
  c_app: cover property (app_cmd_go);
endmodule : iom_chk

bind iom_cmd_handler iom_chk u_chk (.clk(clk), .rst_n(rst_n), .req(req),
  .frame_done(frame_done), .latch_set(latch_set), .rd_valid(rd_valid),
  .busy(busy), .dout(dout), .relay_latched(relay_latched),
  .simple_cmd_en(simple_cmd_en), .minmax_clear(minmax_clear),
  .evt_req(evt_req), .evt_method(evt_method), .app_cmd_go(app_cmd_go));

// ===== testbench/iom_master.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Remote master writing the command block
// ---------------------------------------------------------------
module iom_master
  import iom_pkg::*;
(
  input wire logic clk,
  input wire logic busy,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  output iom_reg_req_s req,
  output logic frame_done
);
  // Bus idle at time zero
  initial
  begin
    req = '0;
    frame_done = 1'b0;
  end

  // Strobe left high so back to back words never toggle in one step
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    req = '{1'b1, 1'b0, a, d};
    @(posedge clk);
    #1;
  endtask : wr

  // Released lines show inverted values, never stale ones
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    req = '{1'b0, 1'b1, a, ~req.wdata};
    @(posedge clk);
    #1;
    req = '{1'b0, 1'b0, ~a, ~req.wdata};
    d = rd_valid ? rd_data : 16'hxxxx;
    @(posedge clk);
    #1;
  endtask : rd

  // Whole block, then trigger, then bounded wait for idle
  task automatic cmd(input logic [15:0] c, n, dst, sec,
                     input logic [31:0] pw, input logic [15:0] p1, p2);
    wr(ADDR_CMD_CODE, c);
    wr(ADDR_PARAM_COUNT, n);
    wr(ADDR_DEST_SELECT, dst);
    wr(ADDR_SEC_TYPE, sec);
    wr(ADDR_PW_HI, pw[31:16]);
    wr(ADDR_PW_LO, pw[15:0]);
    wr(ADDR_PARAM_ONE, p1);
    wr(ADDR_PARAM_TWO, p2);
    req = '{1'b0, 1'b0, ~req.addr, ~req.wdata};
    frame_done = 1'b1;
    @(posedge clk);
    #1;
    frame_done = 1'b0;
    repeat (8)
    begin
      if (busy === 1'b1)
      begin
        @(posedge clk);
        #1;
      end
    end
  endtask : cmd
endmodule : iom_master

// ===== testbench/tb.sv
`timescale 1ns/100ps
module tb
  import iom_pkg::*;
  ;
  localparam logic [31:0] PA = 32'h1234_5678;
  localparam logic [31:0] PO = 32'h0bad_cafe;
  localparam logic [15:0] CO = CMD_CHANGE_OUTPUT;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic frame_done;
  iom_reg_req_s req;
  iom_app_cfg_s app_cfg = '0;
  logic strap = 1'b0;
  logic [2:0] latch_set = '0;
  logic [7:0] alarm_in = '0;
  logic [2:0] dout, relay_latched, pl;
  logic [15:0] rd_data, evt_method, app_cmd_code, v;
  logic rd_valid, busy, simple_cmd_en, minmax_clear, evt_req, app_cmd_go;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [15:0] ac [6] = '{CMD_PRESET_CRADLE_CNT, CMD_PRESET_REGREASE,
    CMD_LIGHT_CONTROL, CMD_LOAD_CONTROL, CMD_PRESET_PULSE_CNT,
    CMD_PRESET_TEMP_CNT};

  iom_cmd_handler dut (.clk, .rst_n, .req, .frame_done,
    .module_strap(strap), .app_cfg, .out_user_def(3'b011),
    .admin_pw(PA), .oper_pw(PO), .alarm_in,
    .alarm_resettable(8'h0f), .latch_set, .rd_data, .rd_valid,
    .busy, .dout, .relay_latched, .simple_cmd_en, .minmax_clear,
    .evt_req, .evt_method, .app_cmd_go, .app_cmd_code);
  iom_master m (.clk, .busy, .rd_valid, .rd_data, .req, .frame_done);

  // ---------------------------------------------------------------
  // Clock, ceiling and report
  // ---------------------------------------------------------------
  initial
  begin
    forever #4 clk = ~clk;
  end

  // A hang ends the run as a mismatch
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] g, e);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Pulses are caught before the status reads let them fall
  task automatic run(input logic [15:0] c, n, s, input logic [31:0] p,
                     input logic [15:0] a, b, e);
    m.cmd(c, n, DEST_FIRST, s, p, a, b);
    pl = {minmax_clear, evt_req, app_cmd_go};
    m.rd(ADDR_CMD_STATUS, v);
    chk(v, e);
    m.rd(ADDR_LAST_CODE, v);
    chk(v, c);
  endtask : run

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    m.rd(ADDR_OUTPUT_STATUS, v);
    chk(v, 16'h0040);
    m.rd(ADDR_CMD_CODE, v);
    chk(v, 16'h0);
    m.rd(16'h1f70, v);
    chk(v, 16'h0);
    $display("test reset done");
    run(CO, 16'hd, 16'h1, PA, 16'h1, VALUE_ON, 16'h0);
    run(CO, 16'hd, 16'h1, PO, 16'h2, VALUE_ON, 16'h0);
    run(CO, 16'hd, 16'h1, PA, 16'h1, VALUE_OFF, 16'h0);
    chk(16'(dout), 16'h2);
    run(CO, 16'hd, 16'h1, PA, 16'h3, VALUE_ON, 16'h6);
    run(CO, 16'hd, 16'h1, PA, 16'h4, VALUE_ON, 16'h6);
    run(CO, 16'hd, 16'h1, PA, 16'h2, 16'h0200, 16'h6);
    run(CO, 16'hc, 16'h1, PA, 16'h2, VALUE_OFF, 16'h3);
    run(CO, 16'hd, 16'h0, PA, 16'h2, VALUE_OFF, 16'h4);
    run(CO, 16'hd, 16'h1, 32'h0, 16'h2, VALUE_OFF, 16'h5);
    chk(16'(dout), 16'h2);
    m.cmd(CMD_RESET_MINMAX, 16'ha, DEST_SECOND, 16'h1, PA, 16'h0, 16'h0);
    m.rd(ADDR_LAST_CODE, v);
    chk(v, CO);
    $display("test outputs done");
    alarm_in = 8'h3c;
    repeat (4) @(posedge clk);
    #1;
    m.rd(ADDR_ALARM_STATUS, v);
    chk(v, 16'h003c);
    alarm_in = 8'h08;
    run(CMD_RESET_ALARMS, 16'ha, 16'h1, PA, 16'h0, 16'h0, 16'h0);
    m.rd(ADDR_ALARM_STATUS, v);
    chk(v, 16'h0038);
    $display("test alarms done");
    run(CMD_SIMPLE_ENABLE, 16'hb, 16'h1, PA, 16'h0, 16'h0, 16'h0);
    chk(16'(simple_cmd_en), 16'h0);
    run(CMD_SIMPLE_ENABLE, 16'hb, 16'h1, PA, 16'h01ab, 16'h0, 16'h0);
    chk(16'(simple_cmd_en), 16'h1);
    run(CMD_SIMPLE_ENABLE, 16'hb, 16'h1, PA, 16'h0200, 16'h0, 16'h6);
    chk(16'(simple_cmd_en), 16'h1);
    latch_set = 3'b111;
    @(posedge clk);
    #1 latch_set = 3'b000;
    chk(16'(relay_latched), 16'h7);
    run(CMD_ACK_LATCH, 16'hb, 16'h1, PA, 16'h0200, 16'h0, 16'h0);
    chk(16'(relay_latched), 16'h5);
    run(CMD_ACK_LATCH, 16'hb, 16'h1, PA, 16'hff00, 16'h0, 16'h0);
    chk(16'(relay_latched), 16'h0);
    run(CMD_ACK_LATCH, 16'hb, 16'h1, PA, 16'h0400, 16'h0, 16'h6);
    m.rd(ADDR_OUTPUT_STATUS, v);
    chk(v, 16'h0042);
    $display("test simple and latch done");
    run(CMD_RESET_MINMAX, 16'ha, 16'h1, PA, 16'h0, 16'h0, 16'h0);
    chk(16'(pl), 16'h4);
    run(CMD_GET_EVENTS, 16'h1b, 16'h0, 32'h0, 16'h0, 16'h2, 16'h0);
    chk(16'(pl), 16'h2);
    chk(evt_method, 16'h2);
    run(CMD_GET_EVENTS, 16'h1b, 16'h0, 32'h0, 16'h0, 16'h1, 16'h6);
    run(CMD_LIGHT_CONTROL, 16'ha, 16'h1, PA, 16'h0, 16'h0, 16'h2);
    chk(16'(pl), 16'h0);
    app_cfg = '1;
    foreach (ac[i])
    begin
      run(ac[i], 16'ha, 16'h1, PA, 16'h0, 16'h0, 16'h0);
      chk(16'(pl), 16'h1);
      chk(app_cmd_code, ac[i]);
    end
    run(16'h04d2, 16'ha, 16'h1, PA, 16'h0, 16'h0, 16'h1);
    $display("test commands done");
    // Strap needs three idle edges before the next frame
    strap = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    m.cmd(CO, 16'hd, DEST_SECOND, 16'h1, PA, 16'h1, VALUE_ON);
    m.cmd(CO, 16'hd, DEST_FIRST, 16'h1, PA, 16'h2, VALUE_OFF);
    chk(16'(dout), 16'h3);
    $display("test strap done");
    summarize();
  end
endmodule : tb
